// ===== rtl/conv_host_port.sv
/*
  conversion control and parallel readout of a 16-bit sampling converter.
  assumes select, read_convert_n and half_word_select are async pins and
  the analog core hands in a sampled code on sample_code each cycle.
*/
`timescale 1ns/1ps
`include "conv_port_defs.svh"

module conv_host_port (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // host control pins
  input  wire logic                 select_b,
  input  wire logic                 read_convert_n,
  input  wire logic                 half_word_select,
  // analog core
  input  wire logic [`RES_W-1:0]    sample_code,
  output logic                      hold,
  // status
  output logic                      busy_b,
  // data bus, three signals per pin
  output logic [`RES_W-1:0]         data_out,
  output logic [`RES_W-1:0]         data_oe,
  input  wire logic [`RES_W-1:0]    data_in,
  // byte lane
  output logic [`BYTE_W-1:0]        byte_out,
  output logic                      byte_oe
);
  import conv_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic                sel_s;
  logic                sel_low;
  logic                rc_s;
  logic                rc_low;
  logic                hws1_q;
  logic                hws2_q;
  logic                start_arm_q;
  logic                rc_arm_q;
  logic                conv_cmd;
  logic                abort_cmd;
  conv_state_t         state_q;
  logic [`CNT_W-1:0]   conv_cnt_q;
  logic [`RES_W-1:0]   result_q;
  logic                bus_en;
  logic [`BYTE_W-1:0]  byte_sel_d;

  pulse_qual u_sel (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_b    (select_b),
    .sync_b   (sel_s),
    .qual_low (sel_low)
  );

  pulse_qual u_rc (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_b    (read_convert_n),
    .sync_b   (rc_s),
    .qual_low (rc_low)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hws1_q <= 1'b0;
      hws2_q <= 1'b0;
    end else begin
      hws1_q <= half_word_select;
      hws2_q <= hws1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a command fires once per low period of the or-ed pair; rearms when
  // either input returns high
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      start_arm_q <= 1'b1;
    end else if (sel_s || rc_s) begin
      start_arm_q <= 1'b1;
    end else if (conv_cmd) begin
      start_arm_q <= 1'b0;
    end
  end

  // abort on read_convert_n alone, once per low period; a start disarms
  // too, else the still-low starting pulse would abort its own conversion
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rc_arm_q <= 1'b1;
    end else if (rc_s) begin
      rc_arm_q <= 1'b1;
    end else if (abort_cmd || conv_cmd) begin
      rc_arm_q <= 1'b0;
    end
  end

  // both qualified low, whichever fell last triggers
  assign conv_cmd  = start_arm_q && sel_low && rc_low;
  // aborts need only read_convert_n; also a full command counts
  assign abort_cmd = (state_q == ST_CONV) &&
                     ((rc_arm_q && rc_low) || conv_cmd);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_TRACK;
      conv_cnt_q <= `CNT_ZERO;
    end else begin
      unique case (state_q)
        ST_TRACK: begin
          if (conv_cmd) begin
            state_q    <= ST_CONV;
            conv_cnt_q <= `CNT_ZERO;
          end
        end
        ST_CONV: begin
          if (abort_cmd) begin
            state_q    <= ST_TRACK;
            conv_cnt_q <= `CNT_ZERO;
          end else if (conv_cnt_q == `CNT_W'(`CONV_CYC - 1)) begin
            state_q <= ST_DONE;
          end else begin
            conv_cnt_q <= conv_cnt_q + `CNT_ONE;
          end
        end
        ST_DONE: begin
          // one cycle so the register is loaded before busy rises
          state_q    <= ST_TRACK;
          conv_cnt_q <= `CNT_ZERO;
        end
        default: begin
          state_q    <= ST_TRACK;
          conv_cnt_q <= `CNT_ZERO;
        end
      endcase
    end
  end

  // sampled code kept as-is: two's complement, 7FFF down to 8000
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      result_q <= `RES_RESET;
    end else if (state_q == ST_CONV && !abort_cmd &&
                 conv_cnt_q == `CNT_W'(`CONV_CYC - 1)) begin
      result_q <= sample_code;
    end
  end

  // busy low through conversion and the load cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_b <= 1'b1;
    end else begin
      busy_b <= !((state_q == ST_TRACK && conv_cmd) ||
                  (state_q == ST_CONV && !abort_cmd));
    end
  end

  // track outside conversion, so acquisition starts at its end
  assign hold = (state_q != ST_TRACK);

  ////////////////////////////////////////////////////////////////////////
  // bus follows levels, so tying select low gives rc rise = enable
  assign bus_en = rc_s && !sel_s;

  // result_q is untouched mid-conversion, so reads give conversion n-1
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_out <= `RES_RESET;
    end else begin
      data_out <= result_q;
    end
  end

  assign data_oe = {`RES_W{bus_en}};

  // byte lane carries one half chosen live, enabling byte reads
  assign byte_sel_d = hws2_q ? result_q[`LO_MSB:`LO_LSB]
                             : result_q[`HI_MSB:`HI_LSB];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      byte_out <= `BYTE_W'(`RES_RESET);
    end else begin
      byte_out <= byte_sel_d;
    end
  end

  assign byte_oe = bus_en;

endmodule // conv_host_port

// ===== rtl/conv_port_defs.svh
/*
  constants for the converter host port: widths, timing figures, codes.
  assumes a 40 MHz system clock; included by bare name.
*/
`ifndef CONV_PORT_DEFS_SVH
`define CONV_PORT_DEFS_SVH

`define CLK_MHZ           40
`define RES_W             16
`define BYTE_W            8
`define HI_MSB            15
`define HI_LSB            8
`define LO_MSB            7
`define LO_LSB            0
// least convert pulse, ns; rounds up to cycles
`define T_CONV_PULSE_NS   40
`define CONV_PULSE_CYC    ((`T_CONV_PULSE_NS * `CLK_MHZ + 999) / 1000)
// conversion time, ns; longest time rounds down
`define T_CONV_NS         2200
`define CONV_CYC          ((`T_CONV_NS * `CLK_MHZ) / 1000)
// previous data valid window after a start, ns
`define T_PREV_VALID_NS   2200
`define PREV_VALID_CYC    ((`T_PREV_VALID_NS * `CLK_MHZ) / 1000)
`define CNT_W             12
`define CNT_ONE           12'h001
`define CNT_ZERO          12'h000
`define RES_RESET         16'h0000
`define CODE_POS_FS       16'h7FFF
`define CODE_NEG_FS       16'h8000

`endif

// ===== rtl/conv_port_pkg.sv
/*
  types for the converter host port.
  assumes conv_port_defs.svh is present on the include path.
*/
package conv_port_pkg;
  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV  = 2'b01,
    ST_DONE  = 2'b11
  } conv_state_t;
endpackage

// ===== rtl/pulse_qual.sv
/*
  two-flop synchroniser plus low-level duration qualifier.
  assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "conv_port_defs.svh"

module pulse_qual (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // raw pin, active low
  input  wire logic pin_b,
  // synchronised level and qualified-low level
  output logic      sync_b,
  output logic      qual_low
);

  logic                sync1_q;
  logic                sync2_q;
  logic [`CNT_W-1:0]   cnt_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_b;
      sync2_q <= sync1_q;
    end
  end

  // count how long the line has stayed low; glitches below 2 cycles (50 ns) drop out
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= `CNT_ZERO;
    end else if (sync2_q) begin
      cnt_q <= `CNT_ZERO;
    end else if (cnt_q != `CNT_W'(`CONV_PULSE_CYC)) begin
      cnt_q <= cnt_q + `CNT_ONE;
    end
  end

  assign sync_b   = sync2_q;
  assign qual_low = (cnt_q == `CNT_W'(`CONV_PULSE_CYC));

endmodule // pulse_qual

// ===== tb/conv_host_port_checker.sv
/* pin assertions for the converter host port.
   assumes a bind from the testbench and one 40 MHz clock. */
`timescale 1ns/1ps
`include "conv_port_defs.svh"
module conv_host_port_checker (
  // clock, reset, host pins
  input wire logic        clk_sys, rst_b, select_b, read_convert_n,
  input wire logic        half_word_select, hold, busy_b, byte_oe,
  // data
  input wire logic [15:0] sample_code, data_out, data_oe,
  input wire logic [7:0]  byte_out
);
  logic [7:0] lo_cnt_q;
  logic       abort_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // busy low length; abort flag tells a cut-short conversion apart
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) lo_cnt_q <= 8'h00;
    else lo_cnt_q <= busy_b ? 8'h00 : lo_cnt_q + 8'h01;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) abort_q <= 1'b0;
    else abort_q <= !busy_b && (abort_q || $fell(read_convert_n));
  end
  ////////////////////////////////////////////////////////////////////////////
  a_float_desel: assert property (select_b[*4] |-> data_oe == 16'h0000)
    else $error("bus driven while deselected");
  a_float_conv: assert property (!read_convert_n[*4] |-> !byte_oe)
    else $error("bus driven in convert mode");
  a_drive_read: assert property ((!select_b && read_convert_n)[*4]
    |-> &data_oe)
    else $error("bus not driven in read mode");
  a_lane_enable: assert property (byte_oe == data_oe[0])
    else $error("byte lane enable differs");
  a_start_hold: assert property ($fell(busy_b) |-> hold
    && $past(select_b, 3) == 1'b0 && $past(read_convert_n, 3) == 1'b0)
    else $error("start without both pins low");
  a_busy_time: assert property ($rose(busy_b) && !abort_q
    && lo_cnt_q != 8'h00 |-> lo_cnt_q == `CONV_CYC + 1 && !hold)
    else $error("busy low time wrong");
  a_abort_fast: assert property ($fell(read_convert_n) && !busy_b
    |-> ##[1:8] busy_b)
    else $error("abort did not end busy");
  a_result_word: assert property ($rose(busy_b) && !abort_q
    && lo_cnt_q != 8'h00 |=> data_out == sample_code)
    else $error("result word wrong");
  a_byte_upper: assert property ((!half_word_select && $stable(data_out))[*5]
    |-> byte_out == data_out[15:8])
    else $error("upper byte wrong");
  a_byte_lower: assert property ((half_word_select && $stable(data_out))[*5]
    |-> byte_out == data_out[7:0])
    else $error("lower byte wrong");
  c_convert: cover property ($rose(busy_b) && !abort_q);
  c_abort: cover property ($rose(busy_b) && abort_q);
  c_read_busy: cover property (!busy_b && &data_oe);
endmodule // conv_host_port_checker

// ===== tb/host_model.sv
/* host side: drives select and read/convert, latches the result.
   assumes requests come from the bench on clk_sys edges. */
`timescale 1ns/1ps
module host_model (
  // clock and requests
  input  wire logic        clk_sys, sel_req, rc_req, busy_b,
  input  wire logic [15:0] data_out,
  // pins and latched word
  output logic             select_b = 1'b1,
  output logic             read_convert_n = 1'b1,
  output logic [15:0]      word_q
);
  logic [1:0] busy_q = 2'b11;
  // pins move just after an edge and hold until the next request
  always @(posedge clk_sys) begin
    select_b <= sel_req;
    read_convert_n <= rc_req;
  end
  // latch one stage after busy rises, past the output register
  always @(posedge clk_sys) begin
    busy_q <= {busy_q[0], busy_b};
    if (busy_q == 2'b01) word_q <= data_out;
  end
endmodule // host_model

// ===== tb/testbench.sv
/* scenario bench for the converter host port with host model and checker.
   assumes the 40 MHz clock and the shared constants header. */
`timescale 1ns/1ps
`include "conv_port_defs.svh"
module testbench;
  import conv_port_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, sel = 1'b1, rc = 1'b1, hws = 1'b0;
  logic select_b, read_convert_n, hold, busy_b, byte_oe;
  logic [15:0] code = 16'h0000, data_out, data_oe, word_q;
  logic [7:0]  byte_out;
  logic [15:0] codes [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  int miscompares = 0, n_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  conv_host_port i_conv_host_port (.clk_sys(clk_sys), .rst_b(rst_b),
    .select_b(select_b), .read_convert_n(read_convert_n),
    .half_word_select(hws), .sample_code(code), .hold(hold),
    .busy_b(busy_b), .data_out(data_out), .data_oe(data_oe),
    .data_in(16'h0000), .byte_out(byte_out), .byte_oe(byte_oe));
  host_model i_host_model (.clk_sys(clk_sys), .sel_req(sel), .rc_req(rc),
    .busy_b(busy_b), .data_out(data_out), .select_b(select_b),
    .read_convert_n(read_convert_n), .word_q(word_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic pins(logic s, logic r, int n);
    sel <= s;
    rc <= r;
    repeat (n) @(posedge clk_sys);
  endtask
  // bounded wait; n counts edges until busy reads lvl
  task automatic wait_busy(logic lvl, output int n);
    n = 0;
    while (busy_b !== lvl && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic convert(logic [15:0] c, logic rc_first);
    int n;
    code <= c;
    pins(rc_first, !rc_first, 2);
    pins(1'b0, 1'b0, 4);
    wait_busy(1'b0, n);
    check("start float", 16'h0000, data_oe);
    pins(1'b0, 1'b1, 0);
    wait_busy(1'b1, n);
    check("busy cycles", 16'(`CONV_CYC + 1), 16'(n));
    repeat (3) @(posedge clk_sys);
    check("word", c, data_out);
    check("latched", c, word_q);
    check("enable", 16'hFFFF, data_oe);
    hws <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check("low byte", {8'h00, c[7:0]}, {8'h00, byte_out});
    hws <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check("high byte", {8'h00, c[15:8]}, {8'h00, byte_out});
    pins(1'b1, 1'b1, 80);
    $display("test convert %h done", c);
  endtask
  task automatic read_during();
    int n;
    code <= 16'h1234;
    pins(1'b0, 1'b0, 4);
    wait_busy(1'b0, n);
    pins(1'b0, 1'b1, 10);
    check("previous", 16'h8000, data_out);
    pins(1'b1, 1'b1, 0);
    wait_busy(1'b1, n);
    repeat (3) @(posedge clk_sys);
    check("deselect float", 16'h0000, data_oe);
    check("new word", 16'h1234, data_out);
    pins(1'b1, 1'b1, 80);
    $display("test read_during done");
  endtask
  task automatic abort_run();
    int n;
    code <= 16'h5A5A;
    pins(1'b0, 1'b0, 4);
    wait_busy(1'b0, n);
    pins(1'b0, 1'b1, 20);
    pins(1'b0, 1'b0, 4);
    wait_busy(1'b1, n);
    check("abort fast", 16'h0001, {15'h0, n < 8});
    pins(1'b0, 1'b0, 10);
    check("no restart", 16'h0001, {15'h0, busy_b});
    check("word kept", 16'h1234, data_out);
    pins(1'b1, 1'b1, 100);
    $display("test abort done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("busy idle", 16'h0001, {15'h0, busy_b});
    for (int i = 0; i < 4; i++) convert(codes[i], i[0]);
    read_during();
    abort_run();
    convert(16'h5A5A, 1'b0);
    print_verdict();
  end
  // the tests need about 1,300 cycles
  initial begin
    #125000;
    miscompares++;
    print_verdict();
  end
endmodule // testbench
bind conv_host_port conv_host_port_checker i_chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .select_b(select_b), .read_convert_n(read_convert_n),
  .half_word_select(half_word_select), .hold(hold), .busy_b(busy_b),
  .byte_oe(byte_oe), .sample_code(sample_code), .data_out(data_out),
  .data_oe(data_oe), .byte_out(byte_out));
